/* src/iag_params.svh */
// Register indices, field positions, reset values and timing counts for the interrupt block
`ifndef IAG_PARAMS_SVH
`define IAG_PARAMS_SVH

`define IAG_IDX_CSD 16'hfc00
`define IAG_IDX_ICR 16'hfc01
`define IAG_IDX_MR 16'hfc02
`define IAG_IDX_TC 16'hfc03
`define IAG_IDX_BSR 16'hfc05
`define IAG_IDX_RPI 16'hfc07
`define IAG_IDX_DMACTL 16'hfc10
`define IAG_IDX_DMA_INTERRUPT_FLAG 16'hfc14
`define IAG_IDX_ISR 16'hfe04
`define IAG_IDX_IMR 16'hfe0d
`define IAG_IDX_IDR 16'hfe0e
`define IAG_IDX_ICLR 16'hfe10

`define IAG_MR_DMA_MODE 1
`define IAG_MR_MON_BSY 2
`define IAG_MR_PAR_IRQ 4
`define IAG_MR_PAR_CHK 5
`define IAG_ICR_DATA_BUS 0
`define IAG_ICR_ASSERT_RST 7
`define IAG_BSR_MISMATCH 3
`define IAG_BSR_IRQ_ACT 4
`define IAG_BSR_PAR_ERR 5
`define IAG_BSR_EOD 7
`define IAG_TC_LAST_BYTE 7
`define IAG_DMA_TIP 0
`define IAG_DMA_IEN 1
`define IAG_DMA_INTERRUPT_FLAG_FLAG 0

`define IAG_ISR_EXT0 0
`define IAG_ISR_EXT1 1
`define IAG_ISR_T1 2
`define IAG_ISR_T2 3
`define IAG_ISR_DMA 4
`define IAG_ISR_TWS1 5
`define IAG_ISR_TWS0 6
`define IAG_ISR_SCSI 7

`define IAG_REG_RESET 8'h00
`define IAG_RESP_OKAY 2'b00
`define IAG_RESP_SLVERR 2'b10

`define IAG_CLK_NS 5
`define IAG_BUS_CLEAR_NS 800
`define IAG_BUS_SETTLE_NS 400
`define IAG_BUS_CLEAR_CYC (`IAG_BUS_CLEAR_NS / `IAG_CLK_NS)
`define IAG_BUS_SETTLE_CYC ((`IAG_BUS_SETTLE_NS + `IAG_CLK_NS - 1) / `IAG_CLK_NS)

`endif

/* src/iag_pkg.sv */
// Types shared by the interrupt aggregation block
package iag_pkg;
  typedef logic [7:0] iag_reg_t;
  typedef enum logic [2:0] {
    IAG_BSY_IDLE = 3'b001,
    IAG_BSY_SETTLE = 3'b010,
    IAG_BSY_ARMED = 3'b100
  } iag_bsy_state_t;
endpackage

/* src/iag_sync.sv */
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module iag_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_q[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          meta_q[g] <= async_i[g];
          sync_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule // iag_sync
`default_nettype wire

/* src/iag_top.sv */
// Interrupt aggregation, SCSI/DMA interrupt sources and AXI4-Lite registers
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "iag_params.svh"
module iag_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic scsi_rst_line_i,
  input wire logic scsi_bsy_line_i,
  input wire logic scsi_req_line_i,
  input wire logic scsi_io_line_i,
  input wire logic scsi_cd_line_i,
  input wire logic scsi_msg_line_i,
  input wire logic [7:0] scsi_data_line_i,
  input wire logic [1:0] external_irq_pins_i,
  input wire logic sel_event_i,
  input wire logic initiator_mode_i,
  input wire logic data_parity_bad_i,
  input wire logic dma_rx_byte_i,
  input wire logic transfer_in_progress_i,
  input wire logic dma_receive_i,
  input wire logic scsi_rx_empty_i,
  input wire logic last_byte_sent_i,
  input wire logic [1:0] tws_irq_i,
  input wire logic [1:0] timer_irq_i,
  input wire logic [1:0] sff_irq_i,
  output logic mcu_irq0_o,
  output logic mcu_irq1_o,
  output logic scsi_bus_release_o,
  output logic scsi_assert_rst_o,
  output logic scsi_data_drive_o,
  output logic scsi_req_accept_o
);
  localparam logic [7:0] CLEAR_CYC = 8'(`IAG_BUS_CLEAR_CYC);
  localparam logic [7:0] SETTLE_CYC = 8'(`IAG_BUS_SETTLE_CYC);

  // Pin synchronisation
  logic [14:0] pins_s;
  iag_sync #(.W(15)) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({external_irq_pins_i, scsi_data_line_i, scsi_msg_line_i, scsi_cd_line_i,
              scsi_io_line_i, scsi_req_line_i, scsi_bsy_line_i}),
    .sync_o(pins_s)
  );
  wire logic bsy_s = pins_s[0];
  wire logic req_s = pins_s[1];
  wire logic [2:0] phase_s = pins_s[4:2];
  wire logic [7:0] data_s = pins_s[12:5];
  wire logic [1:0] ext_s = pins_s[14:13];
  logic rst_s;
  iag_sync #(.W(1)) u_sync_rst (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(scsi_rst_line_i),
    .sync_o(rst_s)
  );

  // Registers
  iag_pkg::iag_reg_t mr_q, icr_q, tc_q, dmactl_q, isr_q, imr_q, idr_q;
  iag_pkg::iag_reg_t isr_d;
  logic irq_act_q, par_err_q, eod_q, eod_pend_q, dma_interrupt_flag_q;
  logic rst_prev_q, req_prev_q, tip_prev_q;
  logic [1:0] ext_prev_q;
  logic [7:0] clear_cnt_q, settle_cnt_q;
  iag_pkg::iag_bsy_state_t bsy_st_q, bsy_st_d;

  // AXI write channel capture
  logic aw_have_q, w_have_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  wire logic aw_take = s_axi_awvalid_i && s_axi_awready_o;
  wire logic w_take = s_axi_wvalid_i && s_axi_wready_o;
  assign s_axi_awready_o = !aw_have_q && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_have_q && !s_axi_bvalid_o;
  wire logic wr_go = aw_have_q && w_have_q && !s_axi_bvalid_o;
  wire logic [15:0] widx = awaddr_q[17:2];
  wire logic waddr_ok = (awaddr_q[31:18] == 14'h0000) && (awaddr_q[1:0] == 2'b00);
  wire logic lane0 = wr_go && wstrb_q[0];
  wire logic [7:0] wbyte = wdata_q[7:0];
  wire logic wr_icr = lane0 && waddr_ok && (widx == `IAG_IDX_ICR);
  wire logic wr_mr = lane0 && waddr_ok && (widx == `IAG_IDX_MR);
  wire logic wr_tc = lane0 && waddr_ok && (widx == `IAG_IDX_TC);
  wire logic wr_dma = lane0 && waddr_ok && (widx == `IAG_IDX_DMACTL);
  wire logic wr_isr = lane0 && waddr_ok && (widx == `IAG_IDX_ISR);
  wire logic wr_imr = lane0 && waddr_ok && (widx == `IAG_IDX_IMR);
  wire logic wr_idr = lane0 && waddr_ok && (widx == `IAG_IDX_IDR);
  wire logic wr_iclr = lane0 && waddr_ok && (widx == `IAG_IDX_ICLR);
  wire logic w_mapped = waddr_ok && ((widx == `IAG_IDX_ICR) || (widx == `IAG_IDX_MR) ||
    (widx == `IAG_IDX_TC) || (widx == `IAG_IDX_DMACTL) || (widx == `IAG_IDX_ISR) ||
    (widx == `IAG_IDX_IMR) || (widx == `IAG_IDX_IDR) || (widx == `IAG_IDX_ICLR));

  // AXI read decode; side effects happen on the address handshake
  wire logic ar_take = s_axi_arvalid_i && s_axi_arready_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  wire logic [15:0] ridx = s_axi_araddr_i[17:2];
  wire logic raddr_ok = (s_axi_araddr_i[31:18] == 14'h0000) && (s_axi_araddr_i[1:0] == 2'b00);
  wire logic rd_csd = ar_take && raddr_ok && (ridx == `IAG_IDX_CSD);
  wire logic rd_rpi = ar_take && raddr_ok && (ridx == `IAG_IDX_RPI);
  wire logic rd_dma_interrupt_flag = ar_take && raddr_ok && (ridx == `IAG_IDX_DMA_INTERRUPT_FLAG);

  // SCSI event detection
  wire logic mismatch = (phase_s != tc_q[2:0]);
  wire logic rst_evt = (rst_s && !rst_prev_q) ||
    (wr_icr && wbyte[`IAG_ICR_ASSERT_RST] && !icr_q[`IAG_ICR_ASSERT_RST]);
  wire logic tip_fall = tip_prev_q && !transfer_in_progress_i;
  // Receive completion is held back until the core has drained
  wire logic eod_set = (tip_fall && (!dma_receive_i || scsi_rx_empty_i)) ||
    (eod_pend_q && scsi_rx_empty_i);
  wire logic par_evt = mr_q[`IAG_MR_PAR_CHK] && data_parity_bad_i &&
    (rd_csd || dma_rx_byte_i);
  wire logic par_irq = par_evt && mr_q[`IAG_MR_PAR_IRQ];
  wire logic mm_irq = mr_q[`IAG_MR_DMA_MODE] && mismatch && req_s && !req_prev_q;
  wire logic bsy_loss = (bsy_st_q == iag_pkg::IAG_BSY_ARMED) && !bsy_s &&
    mr_q[`IAG_MR_MON_BSY];
  wire logic scsi_evt = sel_event_i || eod_set || rst_evt || par_irq || mm_irq ||
    bsy_loss;
  wire logic dma_evt = tip_fall && dmactl_q[`IAG_DMA_IEN];
  wire logic [1:0] ext_rise = ext_s & ~ext_prev_q;

  // Status set sources; SCSI events pass through even mid-transfer
  wire logic [7:0] isr_set = {scsi_evt, tws_irq_i[0], tws_irq_i[1], dma_evt, timer_irq_i[1],
    timer_irq_i[0], sff_irq_i[1] | ext_rise[1], sff_irq_i[0] | ext_rise[0]};
  wire logic [7:0] isr_force = wr_isr ? wbyte : 8'h00;
  wire logic [7:0] isr_clr = wr_iclr ? wbyte : 8'h00;
  // Set wins over a same-cycle clear; masking never stops the set
  assign isr_d = (isr_q & ~isr_clr) | isr_set | isr_force;

  always_comb begin
    bsy_st_d = bsy_st_q;
    case (bsy_st_q)
      iag_pkg::IAG_BSY_IDLE: begin
        if (bsy_s) begin
          bsy_st_d = iag_pkg::IAG_BSY_SETTLE;
        end
      end
      iag_pkg::IAG_BSY_SETTLE: begin
        if (!bsy_s) begin
          bsy_st_d = iag_pkg::IAG_BSY_IDLE;
        end else if (settle_cnt_q >= SETTLE_CYC - 8'h01) begin
          bsy_st_d = iag_pkg::IAG_BSY_ARMED;
        end
      end
      iag_pkg::IAG_BSY_ARMED: begin
        if (!bsy_s) begin
          bsy_st_d = iag_pkg::IAG_BSY_IDLE;
        end
      end
      default: bsy_st_d = iag_pkg::IAG_BSY_IDLE;
    endcase
  end

  // Read data mux
  logic [7:0] rbyte;
  logic rmapped;
  always_comb begin
    rbyte = 8'h00;
    rmapped = raddr_ok;
    case (ridx)
      `IAG_IDX_CSD: rbyte = data_s;
      `IAG_IDX_ICR: rbyte = icr_q;
      `IAG_IDX_MR: rbyte = mr_q;
      `IAG_IDX_TC: rbyte = {last_byte_sent_i, tc_q[6:0]};
      `IAG_IDX_BSR: rbyte = {eod_q, 1'b0, par_err_q, irq_act_q, mismatch, 3'b000};
      `IAG_IDX_RPI: rbyte = 8'h00;
      `IAG_IDX_DMACTL: rbyte = {dmactl_q[7:1], transfer_in_progress_i};
      `IAG_IDX_DMA_INTERRUPT_FLAG: rbyte = {7'h00, dma_interrupt_flag_q};
      `IAG_IDX_ISR: rbyte = isr_q;
      `IAG_IDX_IMR: rbyte = imr_q;
      `IAG_IDX_IDR: rbyte = idr_q;
      default: rmapped = 1'b0;
    endcase
  end

  // Bus side effects; REQ and data drive dropped on an initiator mismatch
  wire logic ini_mm = initiator_mode_i && mismatch;
  assign scsi_data_drive_o = icr_q[`IAG_ICR_DATA_BUS] && !ini_mm && !scsi_bus_release_o;
  assign scsi_req_accept_o = req_s && !ini_mm;
  assign scsi_assert_rst_o = icr_q[`IAG_ICR_ASSERT_RST];
  // Release follows the synchronised line within two cycles, far inside the bus clear delay
  assign scsi_bus_release_o = rst_s || (clear_cnt_q != 8'h00);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `IAG_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= w_mapped ? `IAG_RESP_OKAY : `IAG_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `IAG_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h000000, rmapped ? rbyte : 8'h00};
      s_axi_rresp_o <= rmapped ? `IAG_RESP_OKAY : `IAG_RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mr_q <= `IAG_REG_RESET;
      icr_q <= `IAG_REG_RESET;
      tc_q <= `IAG_REG_RESET;
      dmactl_q <= `IAG_REG_RESET;
      imr_q <= `IAG_REG_RESET;
      idr_q <= `IAG_REG_RESET;
      isr_q <= `IAG_REG_RESET;
    end else begin
      if (wr_mr) mr_q <= wbyte;
      if (wr_icr) icr_q <= wbyte;
      if (wr_tc) tc_q <= wbyte;
      if (wr_dma) dmactl_q <= wbyte;
      if (wr_imr) imr_q <= wbyte;
      if (wr_idr) idr_q <= wbyte;
      isr_q <= isr_d;
    end
  end

  // SCSI flags: each set beats a same-cycle clearing read
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_act_q <= 1'b0;
      par_err_q <= 1'b0;
      eod_q <= 1'b0;
      eod_pend_q <= 1'b0;
      dma_interrupt_flag_q <= 1'b0;
    end else begin
      irq_act_q <= scsi_evt || (irq_act_q && !rd_rpi);
      par_err_q <= par_evt || (par_err_q && !rd_rpi);
      eod_q <= eod_set || (eod_q && !transfer_in_progress_i);
      eod_pend_q <= (tip_fall && dma_receive_i && !scsi_rx_empty_i) ||
        (eod_pend_q && !scsi_rx_empty_i && !transfer_in_progress_i);
      dma_interrupt_flag_q <= dma_evt || (dma_interrupt_flag_q && !rd_dma_interrupt_flag);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_prev_q <= 1'b0;
      req_prev_q <= 1'b0;
      tip_prev_q <= 1'b0;
      ext_prev_q <= 2'b00;
      clear_cnt_q <= 8'h00;
      settle_cnt_q <= 8'h00;
      bsy_st_q <= iag_pkg::IAG_BSY_IDLE;
    end else begin
      rst_prev_q <= rst_s;
      req_prev_q <= req_s;
      tip_prev_q <= transfer_in_progress_i;
      ext_prev_q <= ext_s;
      bsy_st_q <= bsy_st_d;
      if (rst_evt) begin
        clear_cnt_q <= CLEAR_CYC;
      end else if (clear_cnt_q != 8'h00) begin
        clear_cnt_q <= clear_cnt_q - 8'h01;
      end
      if (bsy_st_q == iag_pkg::IAG_BSY_SETTLE && bsy_s) begin
        settle_cnt_q <= settle_cnt_q + 8'h01;
      end else begin
        settle_cnt_q <= 8'h00;
      end
    end
  end

  // Outputs registered so the core sees clean levels
  wire logic [7:0] live = isr_q & imr_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mcu_irq0_o <= 1'b0;
      mcu_irq1_o <= 1'b0;
    end else begin
      mcu_irq0_o <= |(live & ~idr_q);
      mcu_irq1_o <= |(live & idr_q);
    end
  end
endmodule // iag_top
`default_nettype wire

/* tb/iag_mcu_model.sv */
// Stand-in for the microcontroller's two interrupt inputs
`timescale 1ns/1ps
`default_nettype none
module iag_mcu_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic irq0_i,
  input wire logic irq1_i,
  output logic [15:0] seen0_o,
  output logic [15:0] seen1_o
);
  logic [1:0] last_q;
  // Counts rises only, as an edge-triggered input would; a held level is one request
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_q <= 2'b00;
      seen0_o <= 16'h0000;
      seen1_o <= 16'h0000;
    end else begin
      last_q <= {irq1_i, irq0_i};
      seen0_o <= seen0_o + {15'h0000, irq0_i & !last_q[0]};
      seen1_o <= seen1_o + {15'h0000, irq1_i & !last_q[1]};
    end
  end
endmodule // iag_mcu_model
`default_nettype wire

/* tb/iag_sva.sv */
// Port-level concurrent checks for the interrupt aggregation block
`timescale 1ns/1ps
`default_nettype none
module iag_sva (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic scsi_rst_line_i,
  input wire logic scsi_req_line_i,
  input wire logic mcu_irq0_o,
  input wire logic mcu_irq1_o,
  input wire logic scsi_bus_release_o,
  input wire logic scsi_data_drive_o,
  input wire logic scsi_req_accept_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic wrote_q;
  // Nothing may reach the core before software has written a register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) wrote_q <= 1'b0;
    else if (s_axi_bvalid_o && s_axi_bready_i) wrote_q <= 1'b1;
  end
  quiet_reset_a: assert property (!wrote_q |-> !mcu_irq0_o && !mcu_irq1_o)
    else $error("irq before any write");
  irq0_hold_a: assert property (mcu_irq0_o && !s_axi_bvalid_o |=> mcu_irq0_o)
    else $error("irq0 dropped without write");
  irq1_hold_a: assert property (mcu_irq1_o && !s_axi_bvalid_o |=> mcu_irq1_o)
    else $error("irq1 dropped without write");
  // Guarded by reset history because the synchroniser is cleared during reset
  rst_release_a: assert property ($past(nrst_i) && $past(nrst_i, 2) &&
    $past(scsi_rst_line_i, 2) |-> scsi_bus_release_o) else $error("bus not released");
  release_min_a: assert property ($rose(scsi_bus_release_o) |=> scsi_bus_release_o [*8])
    else $error("release too short");
  drive_off_a: assert property (scsi_data_drive_o |-> !scsi_bus_release_o)
    else $error("data driven during release");
  req_accept_a: assert property (scsi_req_accept_o |-> $past(scsi_req_line_i, 2))
    else $error("request accepted without line");
  wr_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("late write response");
  rd_resp_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("late read response");
endmodule // iag_sva
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the interrupt aggregation block
`timescale 1ns/1ps
`default_nettype none
`include "iag_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("unexpected %0t: got %h want %h", $time, a, b); end end
module testbench;
  localparam logic [1:0] OK = `IAG_RESP_OKAY;
  localparam logic [1:0] ER = `IAG_RESP_SLVERR;
  int mismatches = 0;
  int checked = 0;
  logic clk_i, nrst_i, aw_v, w_v, ar_v, rst, bsy, req, sel, init, pbad, transfer_in_progress, rx, empty, lbs;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic mcu_irq0_o, mcu_irq1_o, scsi_bus_release_o, scsi_assert_rst_o, scsi_data_drive_o;
  logic scsi_req_accept_o, drx;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, ext, tws, tmr, sff;
  logic [31:0] s_axi_rdata_o, aw_a, w_d, ar_a;
  logic [2:0] ph;
  logic [7:0] data;
  logic [15:0] seen0, seen1;
  // Row: source pulses, destination, expected status
  logic [24:0] rows [9] = '{{9'h001, 8'h00, 8'h01}, {9'h002, 8'hff, 8'h02},
    {9'h004, 8'h00, 8'h01}, {9'h008, 8'hff, 8'h02}, {9'h010, 8'h00, 8'h04},
    {9'h020, 8'hff, 8'h08}, {9'h040, 8'h00, 8'h40}, {9'h080, 8'hff, 8'h20},
    {9'h100, 8'haa, 8'h80}};
  logic [15:0] rz [6] = '{`IAG_IDX_ISR, `IAG_IDX_IMR, `IAG_IDX_IDR, `IAG_IDX_MR,
    `IAG_IDX_ICR, `IAG_IDX_DMACTL};
  iag_top dut_u (
    .clk_i, .nrst_i, .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o,
    .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_v), .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i(1'b1), .s_axi_araddr_i(ar_a),
    .s_axi_arvalid_i(ar_v), .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i(1'b1), .scsi_rst_line_i(rst), .scsi_bsy_line_i(bsy), .scsi_req_line_i(req),
    .scsi_io_line_i(ph[0]), .scsi_cd_line_i(ph[1]), .scsi_msg_line_i(ph[2]),
    .scsi_data_line_i(data), .external_irq_pins_i(ext), .sel_event_i(sel),
    .initiator_mode_i(init), .data_parity_bad_i(pbad), .dma_rx_byte_i(drx),
    .transfer_in_progress_i(transfer_in_progress), .dma_receive_i(rx), .scsi_rx_empty_i(empty),
    .last_byte_sent_i(lbs), .tws_irq_i(tws), .timer_irq_i(tmr), .sff_irq_i(sff), .mcu_irq0_o,
    .mcu_irq1_o, .scsi_bus_release_o, .scsi_assert_rst_o, .scsi_data_drive_o, .scsi_req_accept_o
  );
  iag_mcu_model mcu_u (.clk_i, .nrst_i, .irq0_i(mcu_irq0_o), .irq1_i(mcu_irq1_o),
    .seen0_o(seen0), .seen1_o(seen1));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] r);
    aw_a <= {14'h0, i, 2'b00};
    w_d <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready_o) aw_v <= 1'b0;
      if (s_axi_wready_o) w_v <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    `CHK(s_axi_bresp_o, r)
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] m, input logic [7:0] e,
                    input logic [1:0] r);
    ar_a <= {14'h0, i, 2'b00};
    ar_v <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready_o) ar_v <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    `CHK(s_axi_rdata_o & {24'h0, m}, {24'h0, e})
    `CHK(s_axi_rresp_o, r)
  endtask
  // Pins go through a synchroniser, so they are held longer than the pulse inputs
  task automatic fire(input logic [8:0] s);
    sff <= s[1:0];
    ext <= s[3:2];
    tmr <= s[5:4];
    tws <= s[7:6];
    sel <= s[8];
    tick(1);
    {sff, tmr, tws, sel} <= '0;
    tick(6);
    ext <= 2'b00;
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    tick(20000);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {nrst_i, aw_v, w_v, ar_v, rst, bsy, req, sel, init, pbad, transfer_in_progress, rx, empty, lbs} = '0;
    {aw_a, w_d, ar_a, ph, data, ext, tws, tmr, sff, drx} = '0;
    tick(4);
    nrst_i <= 1'b1;
    tick(1);
    foreach (rz[k]) rd(rz[k], 8'hff, 8'h00, OK);
    `CHK({mcu_irq1_o, mcu_irq0_o}, 2'b00)
    lbs <= 1'b1;
    tick(3);
    rd(`IAG_IDX_TC, 8'h80, 8'h80, OK);
    rd(16'hfc06, 8'hff, 8'h00, ER);
    wr(`IAG_IDX_BSR, 8'hff, ER);
    wr(`IAG_IDX_IMR, 8'hff, OK);
    foreach (rows[k]) begin
      wr(`IAG_IDX_IDR, rows[k][15:8], OK);
      fire(rows[k][24:16]);
      rd(`IAG_IDX_ISR, 8'hff, rows[k][7:0], OK);
      `CHK(mcu_irq0_o, |(rows[k][7:0] & ~rows[k][15:8]))
      `CHK(mcu_irq1_o, |(rows[k][7:0] & rows[k][15:8]))
      wr(`IAG_IDX_ICLR, 8'hff, OK);
      tick(2);
      `CHK({mcu_irq1_o, mcu_irq0_o}, 2'b00)
    end
    wr(`IAG_IDX_IMR, 8'h00, OK);
    wr(`IAG_IDX_ISR, 8'h90, OK);
    fire(9'h040);
    rd(`IAG_IDX_ISR, 8'hff, 8'hd0, OK);
    `CHK({mcu_irq1_o, mcu_irq0_o}, 2'b00)
    wr(`IAG_IDX_IDR, 8'h10, OK);
    wr(`IAG_IDX_IMR, 8'h10, OK);
    tick(2);
    `CHK({mcu_irq1_o, mcu_irq0_o}, 2'b10)
    wr(`IAG_IDX_IMR, 8'h90, OK);
    tick(2);
    `CHK({mcu_irq1_o, mcu_irq0_o}, 2'b11)
    wr(`IAG_IDX_ICLR, 8'hff, OK);
    wr(`IAG_IDX_IMR, 8'h97, OK);
    wr(`IAG_IDX_IDR, 8'h00, OK);
    wr(`IAG_IDX_DMACTL, 8'h02, OK);
    transfer_in_progress <= 1'b1;
    fire(9'h100);
    `CHK(mcu_irq0_o, 1'b1)
    wr(`IAG_IDX_ICLR, 8'hff, OK);
    transfer_in_progress <= 1'b0;
    tick(3);
    // A finished transfer is also a SCSI core event, so bit 7 joins the DMA bit
    rd(`IAG_IDX_ISR, 8'hff, 8'h90, OK);
    rd(`IAG_IDX_BSR, 8'h80, 8'h80, OK);
    rd(`IAG_IDX_DMA_INTERRUPT_FLAG, 8'h01, 8'h01, OK);
    rd(`IAG_IDX_DMA_INTERRUPT_FLAG, 8'h01, 8'h00, OK);
    rx <= 1'b1;
    transfer_in_progress <= 1'b1;
    tick(3);
    transfer_in_progress <= 1'b0;
    tick(3);
    rd(`IAG_IDX_BSR, 8'h80, 8'h00, OK);
    empty <= 1'b1;
    tick(3);
    rd(`IAG_IDX_BSR, 8'h80, 8'h80, OK);
    wr(`IAG_IDX_ICLR, 8'hff, OK);
    data <= 8'h5a;
    pbad <= 1'b1;
    wr(`IAG_IDX_MR, 8'h20, OK);
    rd(`IAG_IDX_CSD, 8'hff, 8'h5a, OK);
    rd(`IAG_IDX_BSR, 8'h20, 8'h20, OK);
    rd(`IAG_IDX_ISR, 8'h80, 8'h00, OK);
    wr(`IAG_IDX_MR, 8'h30, OK);
    rd(`IAG_IDX_CSD, 8'h00, 8'h00, OK);
    rd(`IAG_IDX_ISR, 8'h80, 8'h80, OK);
    rd(`IAG_IDX_BSR, 8'h30, 8'h30, OK);
    rd(`IAG_IDX_RPI, 8'h00, 8'h00, OK);
    rd(`IAG_IDX_BSR, 8'h30, 8'h00, OK);
    drx <= 1'b1;
    tick(1);
    drx <= 1'b0;
    rd(`IAG_IDX_BSR, 8'h20, 8'h20, OK);
    pbad <= 1'b0;
    wr(`IAG_IDX_MR, 8'h02, OK);
    wr(`IAG_IDX_ICR, 8'h01, OK);
    wr(`IAG_IDX_ICLR, 8'hff, OK);
    init <= 1'b1;
    ph <= 3'b101;
    tick(4);
    req <= 1'b1;
    tick(4);
    rd(`IAG_IDX_BSR, 8'h08, 8'h08, OK);
    rd(`IAG_IDX_ISR, 8'h80, 8'h80, OK);
    `CHK({scsi_data_drive_o, scsi_req_accept_o}, 2'b00)
    wr(`IAG_IDX_TC, 8'h05, OK);
    tick(1);
    `CHK({scsi_data_drive_o, scsi_req_accept_o}, 2'b11)
    rd(`IAG_IDX_BSR, 8'h08, 8'h00, OK);
    {req, init, ph} <= '0;
    wr(`IAG_IDX_TC, 8'h00, OK);
    wr(`IAG_IDX_ICR, 8'h00, OK);
    wr(`IAG_IDX_ICLR, 8'hff, OK);
    rst <= 1'b1;
    tick(4);
    `CHK(scsi_bus_release_o, 1'b1)
    rst <= 1'b0;
    rd(`IAG_IDX_ISR, 8'h80, 8'h80, OK);
    wr(`IAG_IDX_ICLR, 8'hff, OK);
    tick(170);
    `CHK(scsi_bus_release_o, 1'b0)
    wr(`IAG_IDX_ICR, 8'h80, OK);
    tick(2);
    `CHK(scsi_assert_rst_o, 1'b1)
    rd(`IAG_IDX_ISR, 8'h80, 8'h80, OK);
    wr(`IAG_IDX_ICR, 8'h00, OK);
    wr(`IAG_IDX_MR, 8'h04, OK);
    wr(`IAG_IDX_ICLR, 8'hff, OK);
    for (int n = 0; n < 2; n++) begin
      bsy <= 1'b1;
      tick(40 + 50 * n);
      bsy <= 1'b0;
      tick(4);
      rd(`IAG_IDX_ISR, 8'h80, {n[0], 7'h00}, OK);
    end
    `CHK(seen0 != 16'h0000 && seen1 != 16'h0000, 1'b1)
    rd(`IAG_IDX_BSR, 8'h10, 8'h10, OK);
    // Mid-run chip reset must drop the request-active flag without a clearing read
    nrst_i <= 1'b0;
    tick(2);
    nrst_i <= 1'b1;
    tick(1);
    rd(`IAG_IDX_BSR, 8'h10, 8'h00, OK);
    rd(`IAG_IDX_ISR, 8'hff, 8'h00, OK);
    `CHK({mcu_irq1_o, mcu_irq0_o}, 2'b00)
    tally_and_finish();
  end
endmodule // testbench
bind iag_top iag_sva sva_u (
  .clk_i, .nrst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .scsi_rst_line_i, .scsi_req_line_i, .mcu_irq0_o, .mcu_irq1_o, .scsi_bus_release_o,
  .scsi_data_drive_o, .scsi_req_accept_o
);
`default_nettype wire
